// >>> rtl/acx_map.vh
// Register offsets, field positions, sizes and opcodes of the accumulator unit.
`ifndef ACX_MAP_VH
`define ACX_MAP_VH
`define ACX_REG_CTRL      4'h0
`define ACX_REG_OPERAND   4'h1
`define ACX_REG_ACC       4'h2
`define ACX_REG_FLAGS     4'h3
`define ACX_REG_STACK0    4'h4
`define ACX_REG_DEPTH     4'h5
`define ACX_REG_IRQ_STAT  4'h6
`define ACX_REG_IRQ_MASK  4'h7
`define ACX_REG_BITADDR   4'h8
`define ACX_OP_LOAD       3'h0
`define ACX_OP_XORSK      3'h1
`define ACX_OP_CMPW       3'h2
`define ACX_OP_CMPDW      3'h3
`define ACX_OP_CMPBF      3'h4
`define ACX_OP_CMPSK      3'h5
`define ACX_OP_STORE      3'h6
`define ACX_CTRL_GO       8
`define ACX_CTRL_PTR      9
`define ACX_CTRL_CONST    10
`define ACX_FLAG_LT       0
`define ACX_FLAG_EQ       1
`define ACX_FLAG_GT       2
`define ACX_FLAG_ZERO     3
`define ACX_FLAG_NEG      4
`define ACX_IRQ_DONE      0
`define ACX_IRQ_STK_ERR   1
`define ACX_STACK_DEPTH   8
`define ACX_WMEM_WORDS    256
`define ACX_BMEM_BITS     4096
`endif

// >>> rtl/acx_cmp.v
// Unsigned 32-bit magnitude comparator giving one-hot less, equal, greater.
`include "acx_map.vh"
module acx_cmp (
    input  wire [31:0] a,
    input  wire [31:0] b,
    output wire        lt,
    output wire        eq,
    output wire        gt
);
    // Plain unsigned compare of the patterns, so BCD and hex order the same way.
    assign lt = a < b;
    assign eq = a == b;
    assign gt = a > b;
endmodule

// >>> rtl/acx_unit.v
// Accumulator unit: xor with stack, four compares, load and store, register port.
//
// Overview of operation
// - Xor-with-stack xor_with_stack the 32-bit accumulator with stack top into accumulator.
// - Xor-with-stack pops the stack top, deeper entries move up one place.
// - Xor-with-stack sets zero flag when result is zero, else clears it.
// - Xor-with-stack sets negative flag from result bit 31.
// - Each flag keeps its value until another operation drives it.
// - Word compare uses accumulator low 16 bits against one memory word.
// - Compares set less-than when accumulator operand is smaller.
// - Compares set equal when both operands match exactly.
// - Compares set greater-than when accumulator operand is larger.
// - Double compare uses full accumulator against word pair or constant.
// - Bit-field compare gathers 1 to 32 consecutive bits from a start address.
// - Stack compare uses full accumulator against stack top.
// - Stack compare leaves the accumulator unchanged.
// - Compares are plain unsigned magnitude compares of bit patterns.
// - A load pushes the old accumulator onto the stack before writing.
`include "acx_map.vh"
module acx_unit (
    input  wire        clk,
    input  wire        rst_n,
    input  wire [3:0]  reg_addr,
    input  wire [31:0] reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [31:0] reg_rdata,
    input  wire [7:0]  wmem_addr,
    input  wire [15:0] wmem_wdata,
    input  wire        wmem_wr,
    input  wire [11:0] bmem_addr,
    input  wire        bmem_wdata,
    input  wire        bmem_wr,
    output wire        less_than_flag,
    output wire        equal_flag,
    output wire        greater_than_flag,
    output wire        zero_result_flag,
    output wire        negative_result_flag,
    output wire        irq
);
    ////////////////////////////////////////////////////////////////////////////
    reg  [15:0] wmem [0:`ACX_WMEM_WORDS-1];
    reg         bmem [0:`ACX_BMEM_BITS-1];
    reg  [31:0] stack_q [0:`ACX_STACK_DEPTH-1];
    reg  [3:0]  depth_q;
    reg  [31:0] acc_q;
    reg  [31:0] operand_q;
    reg  [11:0] bitaddr_q;
    reg  [10:0] ctrl_q;
    reg  [4:0]  flags_q;
    reg  [1:0]  irq_stat_q;
    reg  [1:0]  irq_mask_q;
    reg  [2:0]  state_q;
    reg  [2:0]  state_d;
    reg  [5:0]  idx_q;
    reg  [31:0] field_q;

    localparam ST_IDLE  = 3'h0;
    localparam ST_EXEC  = 3'h1;
    localparam ST_GATH  = 3'h2;
    localparam ST_FCMP  = 3'h3;

    wire [2:0]  op      = ctrl_q[2:0];
    wire [5:0]  nbits   = (ctrl_q[7:3] == 5'h00) ? 6'h20 : {1'b0, ctrl_q[7:3]};
    wire        go      = reg_wr && reg_addr == `ACX_REG_CTRL && reg_wdata[`ACX_CTRL_GO];
    wire [7:0]  waddr   = ctrl_q[`ACX_CTRL_PTR] ? wmem[operand_q[7:0]][7:0] : operand_q[7:0];
    wire [7:0]  waddr1  = waddr + 8'h01;
    wire [15:0] word_lo = wmem[waddr];
    wire [15:0] word_hi = wmem[waddr1];
    wire        empty   = depth_q == 4'h0;
    wire        needstk = op == `ACX_OP_XORSK || op == `ACX_OP_CMPSK;
    wire [31:0] xor_res = acc_q ^ stack_q[0];

    ////////////////////////////////////////////////////////////////////////////
    // Operand selection for the shared comparator.
    reg  [31:0] cmp_a;
    reg  [31:0] cmp_b;
    always @* begin
        cmp_a = acc_q;
        cmp_b = stack_q[0];
        case (op)
            `ACX_OP_CMPW: begin
                cmp_a = {16'h0000, acc_q[15:0]};
                cmp_b = {16'h0000, word_lo};
            end
            `ACX_OP_CMPDW: begin
                cmp_b = ctrl_q[`ACX_CTRL_CONST] ? operand_q : {word_hi, word_lo};
            end
            `ACX_OP_CMPBF: begin
                cmp_b = field_q;
            end
            default: begin
                cmp_b = stack_q[0];
            end
        endcase
    end

    wire c_lt;
    wire c_eq;
    wire c_gt;
    acx_cmp u_cmp (
        .a  (cmp_a),
        .b  (cmp_b),
        .lt (c_lt),
        .eq (c_eq),
        .gt (c_gt)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer: most operations take one cycle, the bit field walks one bit a cycle.
    always @* begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (go) begin
                    state_d = ST_EXEC;
                end
            end
            ST_EXEC: begin
                state_d = (op == `ACX_OP_CMPBF) ? ST_GATH : ST_IDLE;
            end
            ST_GATH: begin
                if (idx_q + 6'h01 >= nbits) begin
                    state_d = ST_FCMP;
                end
            end
            ST_FCMP: begin
                state_d = ST_IDLE;
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    wire [11:0] baddr = bitaddr_q + {6'h00, idx_q};

    always @(posedge clk) begin
        if (wmem_wr) begin
            wmem[wmem_addr] <= wmem_wdata;
        end
        if (state_q == ST_EXEC && op == `ACX_OP_STORE) begin
            wmem[waddr]  <= acc_q[15:0];
            wmem[waddr1] <= acc_q[31:16];
        end
        if (bmem_wr) begin
            bmem[bmem_addr] <= bmem_wdata;
        end
    end

    wire exec_ok = state_q == ST_EXEC && !(needstk && empty);
    wire do_push = exec_ok && op == `ACX_OP_LOAD;
    wire do_pop  = exec_ok && op == `ACX_OP_XORSK;

    genvar gi;
    generate
        for (gi = 0; gi < `ACX_STACK_DEPTH; gi = gi + 1) begin : g_stk
            always @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    stack_q[gi] <= 32'h00000000;
                end else if (do_push) begin
                    stack_q[gi] <= (gi == 0) ? acc_q : stack_q[(gi == 0) ? 0 : gi - 1];
                end else if (do_pop) begin
                    stack_q[gi] <= (gi == `ACX_STACK_DEPTH - 1) ? 32'h00000000 :
                                   stack_q[(gi == `ACX_STACK_DEPTH - 1) ? gi : gi + 1];
                end
            end
        end
    endgenerate

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q    <= ST_IDLE;
            ctrl_q     <= 11'h000;
            operand_q  <= 32'h00000000;
            bitaddr_q  <= 12'h000;
            acc_q      <= 32'h00000000;
            depth_q    <= 4'h0;
            flags_q    <= 5'h00;
            idx_q      <= 6'h00;
            field_q    <= 32'h00000000;
            irq_stat_q <= 2'h0;
            irq_mask_q <= 2'h0;
        end else begin
            state_q <= state_d;
            if (reg_wr && state_q == ST_IDLE) begin
                case (reg_addr)
                    `ACX_REG_CTRL:     ctrl_q     <= reg_wdata[10:0];
                    `ACX_REG_OPERAND:  operand_q  <= reg_wdata;
                    `ACX_REG_BITADDR:  bitaddr_q  <= reg_wdata[11:0];
                    `ACX_REG_IRQ_MASK: irq_mask_q <= reg_wdata[1:0];
                    default: begin
                    end
                endcase
            end
            if (state_q == ST_EXEC) begin
                idx_q   <= 6'h00;
                field_q <= 32'h00000000;
                case (op)
                    `ACX_OP_LOAD: begin
                        acc_q <= ctrl_q[`ACX_CTRL_CONST] ? operand_q : {word_hi, word_lo};
                        if (depth_q != `ACX_STACK_DEPTH) begin
                            depth_q <= depth_q + 4'h1;
                        end
                    end
                    `ACX_OP_XORSK: begin
                        if (!empty) begin
                            acc_q                 <= xor_res;
                            depth_q               <= depth_q - 4'h1;
                            flags_q[`ACX_FLAG_ZERO] <= xor_res == 32'h00000000;
                            flags_q[`ACX_FLAG_NEG]  <= xor_res[31];
                        end
                    end
                    `ACX_OP_CMPW, `ACX_OP_CMPDW, `ACX_OP_CMPSK: begin
                        // Stack compare only touches the flags, accumulator is held.
                        if (!(needstk && empty)) begin
                            flags_q[2:0] <= {c_gt, c_eq, c_lt};
                        end
                    end
                    default: begin
                    end
                endcase
            end
            if (state_q == ST_GATH) begin
                field_q[idx_q[4:0]] <= bmem[baddr];
                idx_q               <= idx_q + 6'h01;
            end
            if (state_q == ST_FCMP) begin
                flags_q[2:0] <= {c_gt, c_eq, c_lt};
            end
            // Set wins over a write-one clear in the same cycle.
            irq_stat_q <= (irq_stat_q & ~((reg_wr && reg_addr == `ACX_REG_IRQ_STAT) ?
                           reg_wdata[1:0] : 2'h0))
                          | {state_q == ST_EXEC && needstk && empty,
                             state_d == ST_IDLE && state_q != ST_IDLE};
        end
    end

    assign less_than_flag       = flags_q[`ACX_FLAG_LT];
    assign equal_flag           = flags_q[`ACX_FLAG_EQ];
    assign greater_than_flag    = flags_q[`ACX_FLAG_GT];
    assign zero_result_flag     = flags_q[`ACX_FLAG_ZERO];
    assign negative_result_flag = flags_q[`ACX_FLAG_NEG];
    assign irq                  = |(irq_stat_q & irq_mask_q);

    ////////////////////////////////////////////////////////////////////////////
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 32'h00000000;
        end else if (reg_rd) begin
            case (reg_addr)
                `ACX_REG_CTRL:     reg_rdata <= {20'h00000, state_q != ST_IDLE, ctrl_q[10:0]};
                `ACX_REG_OPERAND:  reg_rdata <= operand_q;
                `ACX_REG_ACC:      reg_rdata <= acc_q;
                `ACX_REG_FLAGS:    reg_rdata <= {27'h0000000, flags_q};
                `ACX_REG_STACK0:   reg_rdata <= stack_q[0];
                `ACX_REG_DEPTH:    reg_rdata <= {28'h0000000, depth_q};
                `ACX_REG_IRQ_STAT: reg_rdata <= {30'h00000000, irq_stat_q};
                `ACX_REG_IRQ_MASK: reg_rdata <= {30'h00000000, irq_mask_q};
                `ACX_REG_BITADDR:  reg_rdata <= {20'h00000, bitaddr_q};
                default:           reg_rdata <= 32'h00000000;
            endcase
        end else begin
            reg_rdata <= 32'h00000000;
        end
    end
endmodule

// >>> bench/acx_unit_monitor.sv
// Port checker of the accumulator unit and its bind.
`include "acx_map.vh"
module acx_unit_monitor (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic [3:0]  reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic        less_than_flag,
    input wire logic        equal_flag,
    input wire logic        greater_than_flag,
    input wire logic        zero_result_flag,
    input wire logic        negative_result_flag
);
    wire [4:0] fl = {negative_result_flag, zero_result_flag, greater_than_flag,
                     equal_flag, less_than_flag};
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_go;
        reg_wr && reg_addr == `ACX_REG_CTRL && reg_wdata[`ACX_CTRL_GO];
    endsequence
    sequence s_xor;
        s_go ##0 reg_wdata[2:0] == `ACX_OP_XORSK;
    endsequence
    sequence s_compare_double_word;
        s_go ##0 reg_wdata[2:0] == `ACX_OP_CMPDW;
    endsequence
    sequence s_cmp;
        s_go ##0 (reg_wdata[2:0] >= `ACX_OP_CMPW && reg_wdata[2:0] <= `ACX_OP_CMPSK);
    endsequence
    chk_cmp_onehot: assert property ($onehot0(fl[2:0]))
        else $error("relation flags not exclusive");
    chk_go_latency: assert property (s_go |=> $stable(fl))
        else $error("flags moved one cycle after start");
    chk_flag_groups: assert property ($changed(fl[2:0]) |-> $stable(fl[4:3]))
        else $error("both flag groups moved together");
    chk_flags_read: assert property (reg_rd && reg_addr == `ACX_REG_FLAGS
        |=> reg_rdata == {27'h0, $past(fl)}) else $error("flag readback differs");
    chk_compare_double_word_result: assert property (s_compare_double_word |-> ##2 $onehot(fl[2:0]))
        else $error("double compare gave no relation");
    chk_xor_keeps: assert property (s_xor |-> ##2 $stable(fl[2:0]))
        else $error("xor changed relation flags");
    chk_cmp_keeps: assert property (s_cmp |-> ##2 $stable(fl[4:3]))
        else $error("compare changed result flags");
    chk_unmapped_zero: assert property (reg_rd && reg_addr > 4'h8 |=> reg_rdata == 32'h0)
        else $error("unmapped read not zero");
endmodule
bind acx_unit acx_unit_monitor u_mon (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .less_than_flag, .equal_flag, .greater_than_flag,
    .zero_result_flag, .negative_result_flag);

// >>> bench/testbench.sv
// Self-checking bench of the accumulator unit against a queue model.
`include "acx_map.vh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0;
    logic        wmem_wr = 0, bmem_wr = 0, bmem_wdata = 0;
    logic [3:0]  reg_addr = 0;
    logic [7:0]  wmem_addr = 0;
    logic [15:0] wmem_wdata = 0;
    logic [11:0] bmem_addr = 0;
    logic [31:0] reg_wdata = 0, rnd = 32'hBE64, acc = 0, x, y;
    logic [4:0]  ef = 0;
    logic [31:0] stk[$];
    int          bad_count = 0, num_checks = 0, k;
    wire  [31:0] reg_rdata, fl_w;
    wire         less_than_flag, equal_flag, greater_than_flag;
    wire         zero_result_flag, negative_result_flag, irq;
    acx_unit uut (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .wmem_addr, .wmem_wdata, .wmem_wr, .bmem_addr, .bmem_wdata, .bmem_wr,
        .less_than_flag, .equal_flag, .greater_than_flag, .zero_result_flag,
        .negative_result_flag, .irq);
    assign fl_w = {27'h0, negative_result_flag, zero_result_flag, greater_than_flag,
                   equal_flag, less_than_flag};
    initial forever #2.5 clk = ~clk;
    ////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            bad_count++;
            $display("ERROR %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rdc(input logic [3:0] a, input logic [31:0] e);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, e);
        @(posedge clk);
    endtask
    task automatic wm(input logic [7:0] a, input logic [15:0] d);
        wmem_addr <= a;
        wmem_wdata <= d;
        wmem_wr <= 1'b1;
        @(posedge clk);
        wmem_wr <= 1'b0;
        @(posedge clk);
    endtask
    // Completion is seen through the interrupt, so the done path is exercised on every op but the refused stack compare, where the stack error raises irq.
    task automatic op(input logic [2:0] o, input logic [4:0] n, input logic [1:0] m,
                      input logic [31:0] v, input logic [31:0] es);
        wr(`ACX_REG_OPERAND, v);
        wr(`ACX_REG_CTRL, {21'h0, m, 1'b1, n, o});
        for (int i = 0; i < 60 && irq !== 1'b1; i++)
            @(negedge clk);
        chk({31'h0, irq}, 32'h1);
        @(posedge clk);
        rdc(`ACX_REG_IRQ_STAT, es);
        wr(`ACX_REG_IRQ_STAT, 32'h3);
    endtask
    task automatic ld(input logic [31:0] v);
        op(`ACX_OP_LOAD, 5'h0, 2'b10, v, 32'h1);
        stk.push_front(acc);
        acc = v;
    endtask
    task automatic mcf(input logic [31:0] a, input logic [31:0] b);
        ef[2:0] = {a > b, a == b, a < b};
        chk(fl_w, {27'h0, ef});
        rdc(`ACX_REG_FLAGS, {27'h0, ef});
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    ////////////////////////////////////////
    initial begin
        #100000;
        bad_count++;
        print_verdict();
    end
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        wr(`ACX_REG_IRQ_MASK, 32'h1);
        for (k = 0; k < 3; k++) begin
            rnd = lfsr(rnd);
            x = rnd & 32'h7FFFFFFF | 32'h1;
            y = k == 0 ? x - 1 : (k == 1 ? x : x ^ 32'h80000000);
            ld(x);
            ld(y);
            op(`ACX_OP_CMPSK, 5'h0, 2'b00, 32'h0, 32'h1);
            mcf(acc, stk[0]);
            rdc(`ACX_REG_ACC, acc);
            op(`ACX_OP_XORSK, 5'h0, 2'b00, 32'h0, 32'h1);
            acc = acc ^ stk.pop_front();
            ef[4:3] = {acc[31], acc == 0};
            chk(fl_w, {27'h0, ef});
            rdc(`ACX_REG_ACC, acc);
            rdc(`ACX_REG_STACK0, stk[0]);
            rdc(`ACX_REG_DEPTH, 32'(stk.size()));
        end
        $display("stack tests done");
        for (k = 0; k < 3; k++) begin
            x = acc + k - 1;
            op(`ACX_OP_CMPDW, 5'h0, 2'b10, x, 32'h1);
            mcf(acc, x);
        end
        x = acc + 1;
        wm(8'h0A, x[15:0]);
        wm(8'h0B, x[31:16]);
        op(`ACX_OP_CMPDW, 5'h0, 2'b00, 32'h0A, 32'h1);
        mcf(acc, x);
        ld(32'hFFFF1234);
        wm(8'h14, 16'h1233);
        wm(8'h15, 16'h1235);
        wm(8'h1E, 16'h0015);
        op(`ACX_OP_CMPW, 5'h0, 2'b00, 32'h14, 32'h1);
        mcf({16'h0, acc[15:0]}, 32'h1233);
        op(`ACX_OP_CMPW, 5'h0, 2'b01, 32'h1E, 32'h1);
        mcf({16'h0, acc[15:0]}, 32'h1235);
        // Store the accumulator, overwrite it, then load the pair back from word memory.
        x = acc;
        op(`ACX_OP_STORE, 5'h0, 2'b00, 32'h40, 32'h1);
        ld(32'h0);
        op(`ACX_OP_LOAD, 5'h0, 2'b00, 32'h40, 32'h1);
        stk.push_front(acc);
        acc = x;
        rdc(`ACX_REG_ACC, acc);
        rdc(`ACX_REG_STACK0, stk[0]);
        $display("word compare tests done");
        rnd = lfsr(rnd);
        for (k = 0; k < 32; k++) begin
            bmem_addr <= 12'h064 + k[11:0];
            bmem_wdata <= rnd[k];
            bmem_wr <= 1'b1;
            @(posedge clk);
        end
        bmem_wr <= 1'b0;
        wr(`ACX_REG_BITADDR, 32'h64);
        op(`ACX_OP_CMPBF, 5'h4, 2'b00, 32'h0, 32'h1);
        mcf(acc, {28'h0, rnd[3:0]});
        ld(rnd);
        op(`ACX_OP_CMPBF, 5'h0, 2'b00, 32'h0, 32'h1);
        mcf(acc, rnd);
        $display("bit field tests done");
        // A second reset leaves the stack empty, so a stack compare must be refused.
        rst_n <= 1'b0;
        stk.delete();
        acc = 0;
        ef = 0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        wr(`ACX_REG_IRQ_MASK, 32'h1);
        op(`ACX_OP_CMPW, 5'h0, 2'b00, 32'h14, 32'h1);
        mcf({16'h0, acc[15:0]}, 32'h1233);
        wr(`ACX_REG_IRQ_MASK, 32'h2);
        // A refused op still returns to idle, so done and stack error both rise.
        op(`ACX_OP_CMPSK, 5'h0, 2'b00, 32'h0, 32'h3);
        chk(fl_w, {27'h0, ef});
        rdc(`ACX_REG_ACC, acc);
        wr(`ACX_REG_IRQ_MASK, 32'h0);
        rdc(4'hF, 32'h0);
        $display("error tests done");
        print_verdict();
    end
endmodule
